// ==== src/sel_map.vh ====
// constants for the scan edge execution logic: variant codes, instruction
// classes, flag start values and word encoding limits.
// assumes inclusion by bare name from the design files.
`ifndef SEL_MAP_VH
`define SEL_MAP_VH

// differentiation variant codes (2 bits)
`define SEL_VAR_NONE 2'h0
`define SEL_VAR_UP 2'h1
`define SEL_VAR_DOWN 2'h2

// instruction class codes (3 bits)
`define SEL_CLS_LOAD 3'h0
`define SEL_CLS_SERIES 3'h1
`define SEL_CLS_PARALLEL 3'h2
`define SEL_CLS_SET 3'h3
`define SEL_CLS_RESET 3'h4
`define SEL_CLS_OTHER 3'h5

// previous-value flag at start of operation
`define SEL_INIT_UP_FLAG 1'b1
`define SEL_INIT_DOWN_FLAG 1'b0

// stored flag word value right after start of operation
`define SEL_FLAG_CLEAR 1'b0

// 16-bit word encoding limits
`define SEL_SIGNED_MAX 16'h7FFF
`define SEL_SIGNED_MIN 16'h8000
`define SEL_MINUS_ONE 16'hFFFF
`define SEL_BCD_MAX 16'h9999
`define SEL_BCD_DIGIT_MAX 4'h9
`define SEL_SIGN_BIT 15

`endif

// ==== src/sel_flag_mem.v ====
// previous-value flag store, one bit per edge instruction slot.
// assumes one read and one write port on core_clk; start clears every bit.
`timescale 1ns/100ps
`include "sel_map.vh"

module sel_flag_mem #(
   parameter DEPTH = 64,
   parameter AW = 6
) (
   input wire core_clk,
   input wire rst,
   input wire clear,
   input wire [AW-1:0] rd_addr,
   output reg rd_data_q,
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire wr_data
);

   // flag bits, stored relative to their start value
   reg [DEPTH-1:0] mem_q;

   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_bit
         // one flag bit: cleared at reset or start, else written when addressed
         always @(posedge core_clk or posedge rst) begin
            if (rst) begin
               mem_q[gi] <= `SEL_FLAG_CLEAR;
            end else if (clear) begin
               mem_q[gi] <= `SEL_FLAG_CLEAR;
            end else if (wr_en && (wr_addr == gi)) begin
               mem_q[gi] <= wr_data;
            end
         end
      end
   endgenerate

   // registered read port; old data when read and write collide
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rd_data_q <= `SEL_FLAG_CLEAR;
      end else if (clear) begin
         rd_data_q <= `SEL_FLAG_CLEAR;
      end else begin
         rd_data_q <= mem_q[rd_addr];
      end
   end

endmodule // sel_flag_mem

// ==== src/sel_exec_cond.v ====
// execution condition unit: turns one evaluated instruction per request into
// execute strobes, power flow and refresh requests; also decodes word formats.
// assumes the sequencer presents requests on core_clk and start_op at run start.
// assumes one request per cycle at most and that a slot serves one variant only.
//
// Operation
// (RULE1) plain outputs execute every scan while valid
// (RULE2) plain inputs give power flow when on
// (RULE3) rising outputs execute only on off-to-on
// (RULE4) falling outputs execute only on on-to-off
// (RULE5) rising input gives one-scan power flow
// (RULE6) inverted rising input drops flow one scan
// (RULE7) falling input gives one-scan power flow
// (RULE8) inverted falling input drops flow one scan
// (RULE9) own flag; start: rising on, falling off
// (RULE10) rising fires when condition on, flag off
// (RULE11) interlocked instruction keeps its flag unchanged
// (RULE12) jumped instruction keeps its flag unchanged
// (RULE13) edges fire only when state differs
// (RULE14) falling variant only on five instruction classes
// (RULE15) refresh variant refreshes operand words on execution
// (RULE16) word as unsigned, signed, or bcd digits
// (RULE17) program avoids constant flags on edge instructions
// (RULE18) otherwise flag takes current condition each scan
`timescale 1ns/100ps
`include "sel_map.vh"

module sel_exec_cond #(
   parameter SLOTS = 64,
   parameter SLOT_W = 6,
   parameter ADDR_W = 16
) (
   input wire core_clk,
   input wire rst,
   input wire start_op,
   input wire req_valid,
   input wire [SLOT_W-1:0] req_slot,
   input wire req_cond,
   input wire [1:0] req_variant,
   input wire [2:0] req_class,
   input wire req_is_output,
   input wire req_on_when_off,
   input wire req_invert,
   input wire req_interlocked,
   input wire req_jumped,
   input wire req_refresh,
   input wire req_special,
   input wire [ADDR_W-1:0] req_operand,
   output reg res_valid_q,
   output reg exec_fire_q,
   output reg power_flow_q,
   output reg variant_bad_q,
   output reg refresh_req_q,
   output reg refresh_special_q,
   output reg [ADDR_W-1:0] refresh_addr_q,
   input wire [15:0] word_in,
   output reg word_neg_q,
   output reg word_minus_one_q,
   output reg word_bcd_ok_q,
   output reg [13:0] word_bcd_bin_q
);

   // tells whether a class may carry the falling variant
   function falling_allowed;
      input [2:0] cls;
      begin
         falling_allowed = (cls == `SEL_CLS_LOAD) || (cls == `SEL_CLS_SERIES) ||
                           (cls == `SEL_CLS_PARALLEL) || (cls == `SEL_CLS_SET) ||
                           (cls == `SEL_CLS_RESET);
      end
   endfunction

   // tells whether a nibble is a legal decimal digit
   function digit_ok;
      input [3:0] nib;
      begin
         digit_ok = (nib <= `SEL_BCD_DIGIT_MAX);
      end
   endfunction

   // ---------------- stage 1 request registers ----------------
   reg s1_valid_q; // request under evaluation
   reg [SLOT_W-1:0] s1_slot_q; // its flag slot
   reg s1_cond_q; // present execution condition
   reg [1:0] s1_variant_q; // differentiation variant
   reg [2:0] s1_class_q; // instruction class
   reg s1_is_output_q; // output instruction
   reg s1_on_when_off_q; // output valid on off level
   reg s1_invert_q; // inverted input
   reg s1_hold_q; // interlocked or jumped
   reg s1_refresh_q; // immediate refresh variant
   reg s1_special_q; // refresh names special unit words
   reg [ADDR_W-1:0] s1_operand_q; // operand word address

   // bypass of a write that the flag store read missed
   reg fwd_hit_q; // last write targets the slot in stage 1
   reg fwd_val_q; // value of that write

   wire mem_rd; // stored flag from the store
   reg mem_wr_en; // write back this cycle
   reg mem_wr_val; // stored form of the new flag

   // stage 1 decoded terms
   reg stored_flag; // stored flag after bypass
   reg prev_flag; // previous value as seen by the instruction
   reg rise_edge; // off to on
   reg fall_edge; // on to off
   reg variant_bad; // falling variant on a class that cannot take it
   reg active; // instruction result this scan
   reg fire; // output instruction executes
   reg flow; // input instruction power flow
   reg do_refresh; // refresh request this scan
   reg is_rising; // rising variant selects flag polarity
   reg known_variant; // variant code names a real instruction form

   // flag store; the stored bit is the previous value relative to its start value
   // a clear writes zero everywhere, so start values come back through the xor below
   sel_flag_mem #(
      .DEPTH(SLOTS),
      .AW(SLOT_W)
   ) u_flags (
      .core_clk(core_clk),
      .rst(rst),
      .clear(start_op),
      .rd_addr(req_slot),
      .rd_data_q(mem_rd),
      .wr_en(mem_wr_en),
      .wr_addr(s1_slot_q),
      .wr_data(mem_wr_val)
   );

   // capture the request alongside the flag read
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s1_valid_q <= 1'b0;
         s1_slot_q <= {SLOT_W{1'b0}};
         s1_cond_q <= 1'b0;
         s1_variant_q <= `SEL_VAR_NONE;
         s1_class_q <= `SEL_CLS_LOAD;
         s1_is_output_q <= 1'b0;
         s1_on_when_off_q <= 1'b0;
         s1_invert_q <= 1'b0;
         s1_hold_q <= 1'b0;
         s1_refresh_q <= 1'b0;
         s1_special_q <= 1'b0;
         s1_operand_q <= {ADDR_W{1'b0}};
      end else begin
         // start of operation drops any request in flight
         s1_valid_q <= req_valid && !start_op;
         // payload is taken every cycle; only the valid bit gives it meaning
         s1_slot_q <= req_slot;
         s1_cond_q <= req_cond;
         s1_variant_q <= req_variant;
         s1_class_q <= req_class;
         s1_is_output_q <= req_is_output;
         s1_on_when_off_q <= req_on_when_off;
         s1_invert_q <= req_invert;
         // (RULE11) interlock freezes flag
         // (RULE12) jump freezes flag
         s1_hold_q <= req_interlocked || req_jumped;
         s1_refresh_q <= req_refresh;
         s1_special_q <= req_special;
         s1_operand_q <= req_operand;
      end
   end

   // remember a write that lands on the slot being read now
   // the registered read port misses a write made at the same edge
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fwd_hit_q <= 1'b0;
         fwd_val_q <= `SEL_FLAG_CLEAR;
      end else begin
         fwd_hit_q <= mem_wr_en && (s1_slot_q == req_slot) && !start_op;
         fwd_val_q <= mem_wr_val;
      end
   end

   // evaluate the instruction against its previous-value flag
   always @* begin
      stored_flag = fwd_hit_q ? fwd_val_q : mem_rd;
      is_rising = (s1_variant_q == `SEL_VAR_UP);
      // (RULE9) start values rising on, falling off
      prev_flag = is_rising ? (stored_flag ^ `SEL_INIT_UP_FLAG) : (stored_flag ^ `SEL_INIT_DOWN_FLAG);
      // (RULE10) rising needs cond on, flag off
      rise_edge = s1_cond_q && !prev_flag;
      // (RULE13) edge only on changed state
      fall_edge = !s1_cond_q && prev_flag;
      // (RULE14) falling variant class check
      variant_bad = (s1_variant_q == `SEL_VAR_DOWN) && !falling_allowed(s1_class_q);
      // code 3 is no instruction at all: no flow, no fire, no flag write
      known_variant = (s1_variant_q == `SEL_VAR_NONE) || (s1_variant_q == `SEL_VAR_UP) ||
                      (s1_variant_q == `SEL_VAR_DOWN);
      active = 1'b0;
      fire = 1'b0;
      flow = 1'b0;
      do_refresh = 1'b0;
      mem_wr_en = 1'b0;
      mem_wr_val = `SEL_FLAG_CLEAR;
      case (s1_variant_q)
         `SEL_VAR_NONE: begin
            // (RULE1) output valid level every scan
            // (RULE2) input result passes straight
            active = s1_is_output_q ? (s1_cond_q ^ s1_on_when_off_q) : s1_cond_q;
         end
         `SEL_VAR_UP: begin
            // (RULE3) rising output one scan
            // (RULE5) rising input one scan
            active = rise_edge;
         end
         `SEL_VAR_DOWN: begin
            // (RULE4) falling output one scan
            // (RULE7) falling input one scan
            active = fall_edge && !variant_bad;
         end
         default: begin
            // unused code acts as no instruction
            active = 1'b0;
         end
      endcase
      // refused falling variant and unused code act on nothing, not even inverted flow
      if (s1_valid_q && !s1_hold_q && known_variant && !variant_bad) begin
         if (s1_is_output_q) begin
            fire = active;
         end else begin
            // (RULE6) inverted rising drops flow
            // (RULE8) inverted falling drops flow
            flow = active ^ s1_invert_q;
         end
         // (RULE15) refresh on execution
         do_refresh = s1_refresh_q && (s1_is_output_q ? active : 1'b1);
         // (RULE18) flag follows the condition
         if (((s1_variant_q == `SEL_VAR_UP) || (s1_variant_q == `SEL_VAR_DOWN)) && !variant_bad) begin
            mem_wr_en = !start_op;
            mem_wr_val = is_rising ? (s1_cond_q ^ `SEL_INIT_UP_FLAG) : (s1_cond_q ^ `SEL_INIT_DOWN_FLAG);
         end
      end
   end

   // result registers, one cycle after evaluation: a request taken at one edge
   // shows here after the next edge and stands for one cycle
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         res_valid_q <= 1'b0;
         exec_fire_q <= 1'b0;
         power_flow_q <= 1'b0;
         variant_bad_q <= 1'b0;
         refresh_req_q <= 1'b0;
         refresh_special_q <= 1'b0;
         refresh_addr_q <= {ADDR_W{1'b0}};
      end else if (start_op) begin
         // start of operation clears results
         res_valid_q <= 1'b0;
         exec_fire_q <= 1'b0;
         power_flow_q <= 1'b0;
         variant_bad_q <= 1'b0;
         refresh_req_q <= 1'b0;
         refresh_special_q <= 1'b0;
         refresh_addr_q <= {ADDR_W{1'b0}};
      end else begin
         res_valid_q <= s1_valid_q;
         exec_fire_q <= fire;
         power_flow_q <= flow;
         variant_bad_q <= s1_valid_q && variant_bad;
         refresh_req_q <= do_refresh;
         // unit select and address follow stage 1 every cycle, valid only with the strobe
         refresh_special_q <= s1_special_q;
         refresh_addr_q <= s1_operand_q;
      end
   end

   // ---------------- word format decode ----------------
   wire [3:0] digit_good; // each nibble a decimal digit
   wire [13:0] bcd_bin; // binary value of the four digits

   genvar gd;
   generate
      for (gd = 0; gd < 4; gd = gd + 1) begin : g_digit
         // per-nibble decimal check
         assign digit_good[gd] = digit_ok(word_in[gd*4 +: 4]);
      end
   endgenerate

   // weighted sum of the digits, thousands first
   // largest legal sum is 9999, which fits the 14-bit result
   assign bcd_bin = (word_in[15:12] * 14'd1000) + (word_in[11:8] * 14'd100) +
                    (word_in[7:4] * 14'd10) + {10'h000, word_in[3:0]};

   // register word decode every cycle
   // the sum is masked to zero unless every nibble is a decimal digit
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         word_neg_q <= 1'b0;
         word_minus_one_q <= 1'b0;
         word_bcd_ok_q <= 1'b0;
         word_bcd_bin_q <= 14'h0000;
      end else begin
         // (RULE16) two's complement sign
         word_neg_q <= word_in[`SEL_SIGN_BIT];
         word_minus_one_q <= (word_in == `SEL_MINUS_ONE);
         // (RULE16) four digits up to limit
         word_bcd_ok_q <= (&digit_good) && (word_in <= `SEL_BCD_MAX);
         word_bcd_bin_q <= (&digit_good) ? bcd_bin : 14'h0000;
      end
   end

endmodule // sel_exec_cond

// ==== testbench/sel_exec_cond_checker.sv ====
// checker for the execution condition unit, bound to its ports.
// assumes results appear two samples after the taking edge.
`timescale 1ns/100ps
module sel_exec_cond_checker #(
   parameter SLOT_W = 6,
   parameter ADDR_W = 16
) (
   input wire core_clk,
   input wire rst,
   input wire start_op,
   input wire req_valid,
   input wire [SLOT_W-1:0] req_slot,
   input wire req_cond,
   input wire [1:0] req_variant,
   input wire [2:0] req_class,
   input wire req_is_output,
   input wire req_on_when_off,
   input wire req_invert,
   input wire req_interlocked,
   input wire req_jumped,
   input wire req_refresh,
   input wire req_special,
   input wire [ADDR_W-1:0] req_operand,
   input wire res_valid_q,
   input wire exec_fire_q,
   input wire power_flow_q,
   input wire variant_bad_q,
   input wire refresh_req_q,
   input wire refresh_special_q,
   input wire [ADDR_W-1:0] refresh_addr_q,
   input wire [15:0] word_in,
   input wire word_neg_q,
   input wire word_minus_one_q,
   input wire word_bcd_ok_q,
   input wire [13:0] word_bcd_bin_q
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // request of kind c taken, with no start pulse killing it in flight
   sequence s_take(c);
      (req_valid && !start_op && c) ##1 !start_op;
   endsequence
   a_result_valid: assert property (s_take(1'b1) |=> res_valid_q)
      else $error("no result after request");
   a_plain_out: assert property (s_take(req_variant == 2'h0 && req_is_output && !req_interlocked && !req_jumped)
      |=> exec_fire_q == $past(req_cond ^ req_on_when_off, 2)) else $error("plain output fire wrong");
   a_plain_in: assert property (s_take(req_variant == 2'h0 && !req_is_output && !req_interlocked && !req_jumped)
      |=> power_flow_q == $past(req_cond ^ req_invert, 2)) else $error("plain input flow wrong");
   a_held_quiet: assert property (s_take(req_interlocked || req_jumped)
      |=> !exec_fire_q && !power_flow_q && !refresh_req_q) else $error("held request acted");
   a_bad_variant: assert property (s_take(req_variant == 2'h2 && req_class == 3'h5)
      |=> variant_bad_q && !exec_fire_q) else $error("falling variant on other not refused");
   a_result_cause: assert property (res_valid_q |-> $past(req_valid, 2))
      else $error("result without request");
   a_rise_needs_on: assert property (exec_fire_q && $past(req_variant, 2) == 2'h1 |-> $past(req_cond, 2))
      else $error("rising fire with condition off");
   a_fall_needs_off: assert property (exec_fire_q && $past(req_variant, 2) == 2'h2 |-> !$past(req_cond, 2))
      else $error("falling fire with condition on");
   a_refresh_addr: assert property (refresh_req_q |-> refresh_addr_q == $past(req_operand, 2)
      && $past(req_refresh, 2)) else $error("refresh address wrong");
   a_word_sign: assert property (1'b1 |=> word_neg_q == $past(word_in[15])
      && word_minus_one_q == ($past(word_in) == 16'hFFFF)) else $error("word sign decode wrong");
endmodule // sel_exec_cond_checker
bind sel_exec_cond sel_exec_cond_checker #(
   .SLOT_W(SLOT_W),
   .ADDR_W(ADDR_W)
) sel_exec_cond_checker_inst (
   .core_clk(core_clk),
   .rst(rst),
   .start_op(start_op),
   .req_valid(req_valid),
   .req_slot(req_slot),
   .req_cond(req_cond),
   .req_variant(req_variant),
   .req_class(req_class),
   .req_is_output(req_is_output),
   .req_on_when_off(req_on_when_off),
   .req_invert(req_invert),
   .req_interlocked(req_interlocked),
   .req_jumped(req_jumped),
   .req_refresh(req_refresh),
   .req_special(req_special),
   .req_operand(req_operand),
   .res_valid_q(res_valid_q),
   .exec_fire_q(exec_fire_q),
   .power_flow_q(power_flow_q),
   .variant_bad_q(variant_bad_q),
   .refresh_req_q(refresh_req_q),
   .refresh_special_q(refresh_special_q),
   .refresh_addr_q(refresh_addr_q),
   .word_in(word_in),
   .word_neg_q(word_neg_q),
   .word_minus_one_q(word_minus_one_q),
   .word_bcd_ok_q(word_bcd_ok_q),
   .word_bcd_bin_q(word_bcd_bin_q)
);

// ==== testbench/sel_exec_cond_tb.sv ====
// self-checking bench for the execution condition unit.
// assumes results settle after the first edge following the taking edge.
`timescale 1ns/100ps
`include "sel_map.vh"
module sel_exec_cond_tb;
   reg core_clk = 1'b0; // 200 MHz clock
   reg rst = 1'b1; // held for 16 cycles
   reg start_op = 1'b0;
   reg req_valid = 1'b0;
   reg [5:0] req_slot = 6'h00;
   reg req_cond = 1'b0;
   reg [1:0] req_variant = 2'h0;
   reg [2:0] req_class = 3'h0;
   reg req_is_output = 1'b0, req_on_when_off = 1'b0, req_invert = 1'b0;
   reg req_interlocked = 1'b0, req_jumped = 1'b0, req_refresh = 1'b0, req_special = 1'b0;
   reg [15:0] req_operand = 16'h0000;
   reg [15:0] word_in = 16'h0000;
   wire res_valid_q, exec_fire_q, power_flow_q, variant_bad_q, refresh_req_q, refresh_special_q;
   wire [15:0] refresh_addr_q;
   wire word_neg_q, word_minus_one_q, word_bcd_ok_q;
   wire [13:0] word_bcd_bin_q;
   integer n_fail = 0; // mismatches
   integer comparisons = 0; // checks made
   integer k;
   sel_exec_cond sel_exec_cond_inst (
      .core_clk(core_clk),
      .rst(rst),
      .start_op(start_op),
      .req_valid(req_valid),
      .req_slot(req_slot),
      .req_cond(req_cond),
      .req_variant(req_variant),
      .req_class(req_class),
      .req_is_output(req_is_output),
      .req_on_when_off(req_on_when_off),
      .req_invert(req_invert),
      .req_interlocked(req_interlocked),
      .req_jumped(req_jumped),
      .req_refresh(req_refresh),
      .req_special(req_special),
      .req_operand(req_operand),
      .res_valid_q(res_valid_q),
      .exec_fire_q(exec_fire_q),
      .power_flow_q(power_flow_q),
      .variant_bad_q(variant_bad_q),
      .refresh_req_q(refresh_req_q),
      .refresh_special_q(refresh_special_q),
      .refresh_addr_q(refresh_addr_q),
      .word_in(word_in),
      .word_neg_q(word_neg_q),
      .word_minus_one_q(word_minus_one_q),
      .word_bcd_ok_q(word_bcd_ok_q),
      .word_bcd_bin_q(word_bcd_bin_q)
   );
   // clock toggles every half period
   always #2.5 core_clk = ~core_clk;
   // compare one value and count it
   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task end_of_test;
      begin
         $display("comparisons %0d n_fail %0d", comparisons, n_fail);
         if (n_fail == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // select variant, kind and flag slot
   task mode(input logic [1:0] v, input logic o, input logic [5:0] s);
      begin
         req_variant = v;
         req_is_output = o;
         req_slot = s;
      end
   endtask
   // one instruction per scan, judged after its result lands
   task go(input logic c, input logic ef, input logic ep);
      logic held;
      begin
         held = req_interlocked | req_jumped;
         req_cond = c;
         req_valid = 1'b1;
         @(posedge core_clk);
         @(negedge core_clk);
         req_valid = 1'b0;
         @(posedge core_clk);
         @(negedge core_clk);
         chk("res_valid", 1'b1, res_valid_q);
         chk("fire", ef, exec_fire_q);
         chk("flow", ep, power_flow_q);
         chk("bad", req_variant == `SEL_VAR_DOWN && req_class == `SEL_CLS_OTHER, variant_bad_q);
         chk("refresh", req_refresh & ~held & (req_is_output ? ef : 1'b1), refresh_req_q);
      end
   endtask
   // word decode one cycle after the word is presented
   task wd(input logic [15:0] w, input logic ng, input logic m1, input logic ok, input logic [13:0] b);
      begin
         word_in = w;
         @(posedge core_clk);
         @(negedge core_clk);
         chk("neg", ng, word_neg_q);
         chk("minus_one", m1, word_minus_one_q);
         chk("bcd_ok", ok, word_bcd_ok_q);
         chk("bcd_bin", b, word_bcd_bin_q);
      end
   endtask
   // plain outputs and inputs follow the condition every scan
   task t_plain;
      begin
         mode(`SEL_VAR_NONE, 1'b1, 6'h00);
         go(1'b1, 1'b1, 1'b0);
         go(1'b0, 1'b0, 1'b0);
         req_on_when_off = 1'b1;
         go(1'b0, 1'b1, 1'b0);
         req_on_when_off = 1'b0;
         mode(`SEL_VAR_NONE, 1'b0, 6'h00);
         go(1'b1, 1'b0, 1'b1);
         req_invert = 1'b1;
         go(1'b0, 1'b0, 1'b1);
         req_invert = 1'b0;
      end
   endtask
   // edge outputs and inputs, plain and inverted, from fresh flags
   task t_edges;
      begin
         mode(`SEL_VAR_UP, 1'b1, 6'h03);
         go(1'b1, 1'b0, 1'b0);
         go(1'b0, 1'b0, 1'b0);
         go(1'b1, 1'b1, 1'b0);
         go(1'b1, 1'b0, 1'b0);
         mode(`SEL_VAR_DOWN, 1'b1, 6'h04);
         go(1'b0, 1'b0, 1'b0);
         go(1'b1, 1'b0, 1'b0);
         go(1'b0, 1'b1, 1'b0);
         go(1'b0, 1'b0, 1'b0);
         mode(`SEL_VAR_UP, 1'b0, 6'h05);
         go(1'b1, 1'b0, 1'b0);
         go(1'b0, 1'b0, 1'b0);
         go(1'b1, 1'b0, 1'b1);
         go(1'b1, 1'b0, 1'b0);
         mode(`SEL_VAR_DOWN, 1'b0, 6'h07);
         go(1'b1, 1'b0, 1'b0);
         go(1'b0, 1'b0, 1'b1);
         go(1'b0, 1'b0, 1'b0);
         req_invert = 1'b1;
         mode(`SEL_VAR_UP, 1'b0, 6'h06);
         go(1'b0, 1'b0, 1'b1);
         go(1'b1, 1'b0, 1'b0);
         go(1'b1, 1'b0, 1'b1);
         mode(`SEL_VAR_DOWN, 1'b0, 6'h08);
         go(1'b1, 1'b0, 1'b1);
         go(1'b0, 1'b0, 1'b0);
         go(1'b0, 1'b0, 1'b1);
         req_invert = 1'b0;
      end
   endtask
   // interlocked and jumped scans leave the flag alone
   task t_hold;
      begin
         mode(`SEL_VAR_UP, 1'b1, 6'h09);
         go(1'b0, 1'b0, 1'b0);
         go(1'b1, 1'b1, 1'b0);
         req_interlocked = 1'b1;
         go(1'b0, 1'b0, 1'b0);
         req_interlocked = 1'b0;
         go(1'b1, 1'b0, 1'b0);
         mode(`SEL_VAR_UP, 1'b1, 6'h0A);
         go(1'b0, 1'b0, 1'b0);
         req_jumped = 1'b1;
         go(1'b1, 1'b0, 1'b0);
         req_jumped = 1'b0;
         go(1'b1, 1'b1, 1'b0);
      end
   endtask
   // falling variant on the five accepted classes, then refused on other
   task t_class;
      begin
         for (k = 0; k < 5; k = k + 1) begin
            req_class = k[2:0];
            mode(`SEL_VAR_DOWN, 1'b1, 6'h0B + k[5:0]);
            go(1'b1, 1'b0, 1'b0);
            go(1'b0, 1'b1, 1'b0);
         end
         req_class = `SEL_CLS_OTHER;
         mode(`SEL_VAR_DOWN, 1'b1, 6'h14);
         go(1'b1, 1'b0, 1'b0);
         go(1'b0, 1'b0, 1'b0);
         req_class = `SEL_CLS_LOAD;
         // unused variant code gives no flow
         req_invert = 1'b1;
         mode(2'h3, 1'b0, 6'h16);
         go(1'b1, 1'b0, 1'b0);
         req_invert = 1'b0;
      end
   endtask
   // refresh only when the output fires, with its operand; start clears flags
   task t_refresh_start;
      begin
         mode(`SEL_VAR_UP, 1'b1, 6'h15);
         req_refresh = 1'b1;
         req_special = 1'b1;
         req_operand = 16'h1234;
         go(1'b0, 1'b0, 1'b0);
         go(1'b1, 1'b1, 1'b0);
         chk("refresh_addr", 16'h1234, refresh_addr_q);
         chk("refresh_special", 1'b1, refresh_special_q);
         req_refresh = 1'b0;
         go(1'b0, 1'b0, 1'b0);
         start_op = 1'b1;
         @(posedge core_clk);
         @(negedge core_clk);
         start_op = 1'b0;
         go(1'b1, 1'b0, 1'b0);
      end
   endtask
   // stop a hung run
   initial begin
      #200000;
      n_fail = n_fail + 1;
      end_of_test;
   end
   // main sequence
   initial begin
      repeat (16) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      t_plain;
      t_edges;
      t_hold;
      t_class;
      t_refresh_start;
      wd(16'h7FFF, 1'b0, 1'b0, 1'b0, 14'h0000);
      wd(16'h8000, 1'b1, 1'b0, 1'b1, 14'h1F40);
      wd(16'hFFFF, 1'b1, 1'b1, 1'b0, 14'h0000);
      wd(16'h9999, 1'b1, 1'b0, 1'b1, 14'h270F);
      wd(16'h0010, 1'b0, 1'b0, 1'b1, 14'h000A);
      end_of_test;
   end
endmodule // sel_exec_cond_tb
